// file: core/spi_busy_regs.svh
// Timing constants, frame layout and command codes of the serial control port
`ifndef SPI_BUSY_REGS_SVH
`define SPI_BUSY_REGS_SVH

// ============================================================
// Clock and frame
`define CLK_PERIOD_NS    4
`define FRAME_BITS       16
`define FRAME_CNT_W      5
`define DATA_W           10
`define CMD_W            4
`define TMR_W            21

// ============================================================
// Command codes in the frame's command field
`define CMD_NOP          4'h0
`define CMD_WR_WIPER     4'h1
`define CMD_RD_WIPER     4'h2
`define CMD_NVM_PROG     4'h3
`define CMD_NVM_READ     4'h5

// ============================================================
// Execution times as printed, in ns
`define T_WR_RPERF_NS    2400
`define T_WR_NORM_NS     410
`define T_NVM_PROG_NS    8000000
`define T_RD_WIPER_NS    450
`define T_NVM_READ_NS    1300000
`define T_POWER_UP_NS    2000000

// Longest times round down to whole clock cycles
`define CYC_FLOOR(ns)    ((ns) / `CLK_PERIOD_NS)

// Cycles spent between frame end and the timer start (sync and state)
`define EXEC_LAT_CYC     6
// Shortest execution, used for commands with no documented time
`define NOP_EXEC_CYC     1

// ============================================================
// Power-on value of the nonvolatile wiper memory
`define NVM_RESET_VAL    10'h200

`endif

// file: core/spi_busy_pkg.sv
// Types shared by the serial control port design
package spi_busy_pkg;

  // ============================================================
  // Frame layout, most significant bit first on the wire
  typedef struct packed {
    logic [1:0] spare;  // Ignored
    logic [3:0] cmd;    // Command code
    logic [9:0] data;   // Wiper value or don't care
  } frame_t;

  // ============================================================
  // Command sequencer states
  typedef enum logic [1:0] {
    ST_POWERUP,
    ST_IDLE,
    ST_WAIT_END,
    ST_EXEC
  } state_t;

endpackage

// file: core/spi_busy_timer.sv
// Loadable down-counter that times one command execution
`timescale 1ns/10ps
`include "spi_busy_regs.svh"

module spi_busy_timer #(
  parameter int unsigned W = `TMR_W  // Counter width
) (
  input  wire logic         clk_in,     // Core clock
  input  wire logic         rst_n_in,   // Async reset, active low
  input  wire logic         load_in,    // Start pulse
  input  wire logic [W-1:0] load_val_in, // Cycles to run, at least 1
  output logic              busy_out,   // High while counting
  output logic              done_out    // One-cycle pulse at expiry
);

  logic [W-1:0] cnt_ff;
  logic         done_ff;

  // ============================================================
  // Counter: done fires load_val cycles after the load edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff <= '0;
    end else if (load_in) begin
      cnt_ff <= load_val_in;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - W'(1);
    end
  end

  // Registered expiry pulse keeps the output glitch free
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= !load_in && (cnt_ff == W'(1));
    end
  end

  assign busy_out = (cnt_ff != '0);
  assign done_out = done_ff;

endmodule // spi_busy_timer

// file: core/spi_command_busy_timing.sv
// Serial control port of a digital potentiometer with ready handshake
//
// Notes on behaviour
// - Performance mode: wiper write done, ready released within 2.4 us.
// - Normal mode: wiper write completes, ready released within 410 ns.
// - Nonvolatile program holds ready low at most 8 ms.
// - Wiper readback releases ready within 450 ns.
// - Nonvolatile readback releases ready within 1.3 ms.
// - After power-up, wiper restored from memory within 2 ms.
// - Readback uses clock idle low, data captured on second edge.
`timescale 1ns/10ps
`include "spi_busy_regs.svh"

module spi_command_busy_timing
  import spi_busy_pkg::*;
#(
  parameter int unsigned NVM_PROG_CYC = `CYC_FLOOR(`T_NVM_PROG_NS),
  parameter int unsigned NVM_READ_CYC = `CYC_FLOOR(`T_NVM_READ_NS),
  parameter int unsigned POWER_UP_CYC = `CYC_FLOOR(`T_POWER_UP_NS)
) (
  input  wire logic               clk_in,        // Core clock, 250 MHz
  input  wire logic               rst_n_in,      // Async reset, active low
  input  wire logic               sclk_in,       // Serial clock from host
  input  wire logic               sync_n_in,     // Frame select, active low
  input  wire logic               sdi_in,        // Serial data in
  output logic                    sdo_out,       // Serial data out
  input  wire logic               rperf_mode_in, // Resistor performance mode
  input  wire logic               rdy_in,        // Ready wire level
  output logic                    rdy_out,       // Ready drive value
  output logic                    rdy_oe_out,    // Ready pull-down enable
  output logic [`DATA_W-1:0]      wiper_out      // Wiper register value
);

  // Short execution limits in whole core cycles, rounded down so that
  // the ready line never stays low past the bound
  localparam int unsigned WR_RPERF_CYC = `CYC_FLOOR(`T_WR_RPERF_NS);
  localparam int unsigned WR_NORM_CYC  = `CYC_FLOOR(`T_WR_NORM_NS);
  localparam int unsigned RD_WIPER_CYC = `CYC_FLOOR(`T_RD_WIPER_NS);

  // ============================================================
  // Link domain (serial clock)
  logic [`FRAME_CNT_W-1:0] bit_cnt_ff;
  logic [`FRAME_BITS-1:0]  shift_ff;
  frame_t                  rx_word_ff;
  logic                    rx_tgl_ff;
  logic                    sdo_ff;
  logic                    frame_off;
  frame_t                  rb_word_ff;  // Core domain, read quasi-static

  // The frame's own select clears the counter, so a stopped clock
  // between frames leaves nothing half done
  assign frame_off = sync_n_in | ~rst_n_in;

  // Bit counter advances on each capturing (falling) edge and holds at 16
  always_ff @(negedge sclk_in or posedge frame_off) begin
    if (frame_off) begin
      bit_cnt_ff <= '0;
    end else if (bit_cnt_ff != `FRAME_CNT_W'(`FRAME_BITS)) begin
      bit_cnt_ff <= bit_cnt_ff + `FRAME_CNT_W'(1);
    end
  end

  // Capture data on the falling edge, the second edge of a bit
  always_ff @(negedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_ff <= '0;
    end else if (!sync_n_in) begin
      shift_ff <= {shift_ff[`FRAME_BITS-2:0], sdi_in};
    end
  end

  // Hand the finished word over; extra bits past the word are ignored
  always_ff @(negedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_word_ff <= '0;
      rx_tgl_ff  <= 1'b0;
    end else if (!sync_n_in &&
                 bit_cnt_ff == `FRAME_CNT_W'(`FRAME_BITS - 1)) begin
      rx_word_ff <= frame_t'({shift_ff[`FRAME_BITS-2:0], sdi_in});
      rx_tgl_ff  <= ~rx_tgl_ff;
    end
  end

  // Launch readback bits on the rising edge, idle low clock
  // Select high clears the output at once: the serial clock stops
  // between frames, so no edge would otherwise bring it back low
  always_ff @(posedge sclk_in or posedge frame_off) begin
    if (frame_off) begin
      sdo_ff <= 1'b0;
    end else if (bit_cnt_ff < `FRAME_CNT_W'(`FRAME_BITS)) begin
      sdo_ff <= rb_word_ff[4'(`FRAME_BITS - 1 - 32'(bit_cnt_ff))];
    end else begin
      sdo_ff <= 1'b0;
    end
  end

  assign sdo_out = sdo_ff;

  // ============================================================
  // Crossings into the core domain
  logic sync_n_m_ff, sync_n_s_ff;
  logic tgl_m_ff, tgl_s_ff, tgl_d_ff;
  logic rperf_m_ff, rperf_s_ff;
  logic word_seen;

  // Frame select level, two flops
  // A frame end is acted on only after these settle, which costs the
  // cycles that the timer start values already allow for
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_n_m_ff <= 1'b1;
      sync_n_s_ff <= 1'b1;
    end else begin
      sync_n_m_ff <= sync_n_in;
      sync_n_s_ff <= sync_n_m_ff;
    end
  end

  // Word event as a toggle; edge taken after the second flop
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tgl_m_ff <= 1'b0;
      tgl_s_ff <= 1'b0;
      tgl_d_ff <= 1'b0;
    end else begin
      tgl_m_ff <= rx_tgl_ff;
      tgl_s_ff <= tgl_m_ff;
      tgl_d_ff <= tgl_s_ff;
    end
  end

  // One pulse per received word. The word itself stays put in the
  // link domain until the next 16th falling edge, so the core may
  // copy it as soon as the toggle has been seen.
  assign word_seen = tgl_s_ff ^ tgl_d_ff;

  // Mode pin, two flops
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rperf_m_ff <= 1'b0;
      rperf_s_ff <= 1'b0;
    end else begin
      rperf_m_ff <= rperf_mode_in;
      rperf_s_ff <= rperf_m_ff;
    end
  end

  // ============================================================
  // Command sequencer
  state_t                 state_ff, nxt_state;
  frame_t                 cmd_ff;
  logic [`DATA_W-1:0]     wiper_ff;
  logic [`DATA_W-1:0]     nvm_ff;
  logic                   pu_armed_ff;
  logic                   rdy_oe_ff;
  logic                   tmr_load;
  logic [`TMR_W-1:0]      tmr_val;
  logic                   tmr_busy;
  logic                   tmr_done;

  // Execution length per command, less the sync latency already spent
  // Unknown codes cost one cycle, so the host still sees a busy pulse
  function automatic logic [`TMR_W-1:0] exec_cycles(
    input logic [`CMD_W-1:0] cmd,
    input logic              rperf
  );
    int unsigned cyc;
    cyc = `NOP_EXEC_CYC + `EXEC_LAT_CYC;
    case (cmd)
      `CMD_WR_WIPER: cyc = rperf ? WR_RPERF_CYC : WR_NORM_CYC;
      `CMD_RD_WIPER: cyc = RD_WIPER_CYC;
      `CMD_NVM_PROG: cyc = NVM_PROG_CYC;
      `CMD_NVM_READ: cyc = NVM_READ_CYC;
      default:       cyc = `NOP_EXEC_CYC + `EXEC_LAT_CYC;
    endcase
    return `TMR_W'(cyc - `EXEC_LAT_CYC);
  endfunction

  // Next state; words arriving while busy are dropped, the host must wait
  // Power-up and execute states are left only on the timer's expiry pulse; wait-end leaves on frame end
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_POWERUP:  if (tmr_done) nxt_state = ST_IDLE;
      ST_IDLE:     if (word_seen) nxt_state = ST_WAIT_END;
      ST_WAIT_END: if (sync_n_s_ff) nxt_state = ST_EXEC;
      ST_EXEC:     if (tmr_done) nxt_state = ST_IDLE;
      default:     nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= ST_POWERUP;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Power-up restore timer is started once, on the first edge after reset
  // A later reset starts the restore again, as a power cycle would
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pu_armed_ff <= 1'b0;
    end else if (state_ff == ST_POWERUP) begin
      pu_armed_ff <= 1'b1;
    end
  end

  // Timer start: power-up restore, or frame end of an accepted word
  always_comb begin
    tmr_load = 1'b0;
    tmr_val  = `TMR_W'(`NOP_EXEC_CYC);
    if (state_ff == ST_POWERUP && !pu_armed_ff) begin
      tmr_load = 1'b1;
      tmr_val  = `TMR_W'(POWER_UP_CYC - `EXEC_LAT_CYC);
    end else if (state_ff == ST_WAIT_END && sync_n_s_ff) begin
      tmr_load = 1'b1;
      tmr_val  = exec_cycles(cmd_ff.cmd, rperf_s_ff);
    end
  end

  // One shared timer serves the power-up restore and every command
  spi_busy_timer #(
    .W           (`TMR_W)
  ) u_timer (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .load_in     (tmr_load),
    .load_val_in (tmr_val),
    .busy_out    (tmr_busy),
    .done_out    (tmr_done)
  );

  // Latch the received word; stable since the link needs 16 more edges
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_ff <= '0;
    end else if (state_ff == ST_IDLE && word_seen) begin
      cmd_ff <= rx_word_ff;
    end
  end

  // Command effects take place when execution ends
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wiper_ff <= '0;
    end else if (state_ff == ST_POWERUP && tmr_done) begin
      wiper_ff <= nvm_ff;
    end else if (state_ff == ST_EXEC && tmr_done &&
                 cmd_ff.cmd == `CMD_WR_WIPER) begin
      wiper_ff <= cmd_ff.data;
    end
  end

  // Nonvolatile copy; reset stands in for the retained content
  // Programming stores the current wiper, not the frame's data field
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      nvm_ff <= `NVM_RESET_VAL;
    end else if (state_ff == ST_EXEC && tmr_done &&
                 cmd_ff.cmd == `CMD_NVM_PROG) begin
      nvm_ff <= wiper_ff;
    end
  end

  // Readback word, shifted out during the following frame
  // Other commands leave it alone, so a repeated read frame shows the
  // last readback again
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rb_word_ff <= '0;
    end else if (state_ff == ST_EXEC && tmr_done) begin
      if (cmd_ff.cmd == `CMD_RD_WIPER) begin
        rb_word_ff <= frame_t'({2'b00, cmd_ff.cmd, wiper_ff});
      end else if (cmd_ff.cmd == `CMD_NVM_READ) begin
        rb_word_ff <= frame_t'({2'b00, cmd_ff.cmd, nvm_ff});
      end
    end
  end

  // ============================================================
  // Ready line: pulled low from word capture until execution ends
  // Registered, so the open-drain enable cannot glitch while the
  // sequencer moves between busy states. Reset holds it busy until
  // the power-up restore has finished.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdy_oe_ff <= 1'b1;
    end else begin
      rdy_oe_ff <= (nxt_state != ST_IDLE);
    end
  end

  assign rdy_out    = 1'b0;
  assign rdy_oe_out = rdy_oe_ff;
  assign wiper_out  = wiper_ff;

  // Wire level is only for the bench; timer state gives the same view
  logic unused_ok;
  assign unused_ok = rdy_in & tmr_busy;

endmodule // spi_command_busy_timing

// file: testbench/spi_busy_properties.sv
// Timing checks on the pins of the serial control port
`timescale 1ns/10ps
`include "spi_busy_regs.svh"

module spi_busy_checker #(
  parameter int unsigned NVM_PROG_CYC = `CYC_FLOOR(`T_NVM_PROG_NS), // Cycles
  parameter int unsigned NVM_READ_CYC = `CYC_FLOOR(`T_NVM_READ_NS), // Cycles
  parameter int unsigned POWER_UP_CYC = `CYC_FLOOR(`T_POWER_UP_NS)  // Cycles
) (
  input wire logic               clk_in,        // Core clock
  input wire logic               rst_n_in,      // Async reset
  input wire logic               sclk_in,       // Serial clock
  input wire logic               sync_n_in,     // Frame select
  input wire logic               sdi_in,        // Serial data in
  input wire logic               sdo_out,       // Serial data out
  input wire logic               rperf_mode_in, // Mode pin
  input wire logic               rdy_in,        // Ready wire
  input wire logic               rdy_out,       // Ready drive value
  input wire logic               rdy_oe_out,    // Ready pull-down
  input wire logic [`DATA_W-1:0] wiper_out      // Wiper value
);
  // ============================================================
  // Busy time outside frames; one bound covers every command
  localparam int unsigned WR_RP_CYC = `CYC_FLOOR(`T_WR_RPERF_NS);
  localparam int unsigned MAX_A = (NVM_PROG_CYC > POWER_UP_CYC) ?
    NVM_PROG_CYC : POWER_UP_CYC;
  localparam int unsigned MAX_B = (NVM_READ_CYC > WR_RP_CYC) ?
    NVM_READ_CYC : WR_RP_CYC;
  localparam int unsigned LIM = ((MAX_A > MAX_B) ? MAX_A : MAX_B) + 8;
  logic [31:0] busy_cnt_ff;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      busy_cnt_ff <= '0;
    else if (rdy_oe_out && sync_n_in)
      busy_cnt_ff <= busy_cnt_ff + 32'd1;
    else
      busy_cnt_ff <= '0;
  end

  // ============================================================
  // Properties
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  powerup_hold_a: assert property ($rose(rst_n_in) |-> rdy_oe_out[*8])
    else $error("ready released too soon after reset");
  busy_bound_a: assert property (busy_cnt_ff <= LIM)
    else $error("ready held low too long");
  drive_low_a: assert property (!rdy_out)
    else $error("ready driven high");
  frame_busy_a: assert property ($rose(sync_n_in) |->
    ##[0:10] rdy_oe_out)
    else $error("no busy after frame end");
  release_end_a: assert property ($fell(rdy_oe_out) |-> sync_n_in)
    else $error("ready released inside a frame");
  wiper_upd_a: assert property ($changed(wiper_out) |->
    rdy_oe_out || $past(rdy_oe_out) || $past(rdy_oe_out, 2))
    else $error("wiper changed outside execution");
  sdo_idle_a: assert property (sync_n_in && $past(sync_n_in) &&
    $past(sync_n_in, 2) |-> !sdo_out)
    else $error("data out not low between frames");
  sdo_hold_a: assert property (sclk_in && $past(sclk_in) |->
    $stable(sdo_out))
    else $error("data out moved while clock high");
  cover property ($fell(rdy_oe_out) && !$past(rdy_oe_out, 50));
  cover property ($changed(wiper_out));
  cover property (sdo_out && !sclk_in);
endmodule // spi_busy_checker

bind spi_command_busy_timing spi_busy_checker #(
  .NVM_PROG_CYC(NVM_PROG_CYC),
  .NVM_READ_CYC(NVM_READ_CYC),
  .POWER_UP_CYC(POWER_UP_CYC)
) spi_busy_checker_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .sclk_in(sclk_in), .sync_n_in(sync_n_in), .sdi_in(sdi_in),
  .sdo_out(sdo_out), .rperf_mode_in(rperf_mode_in), .rdy_in(rdy_in),
  .rdy_out(rdy_out), .rdy_oe_out(rdy_oe_out), .wiper_out(wiper_out));

// file: testbench/spi_host_model.sv
// Host serial controller driving frames into the port
`timescale 1ns/10ps

module spi_host_model (
  output logic      sclk_out,   // Serial clock, idles low
  output logic      sync_n_out, // Frame select, active low
  output logic      sdi_out,    // Serial data to device
  input  wire logic sdo_in,     // Serial data from device
  input  wire logic rdy_in      // Ready wire level
);
  initial begin
    sclk_out = 1'b0;
    sync_n_out = 1'b1;
    sdi_out = 1'b0;
  end

  // ============================================================
  // One 16-bit frame; clock only runs inside the frame
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx,
                      output logic ok);
    int i;
    rx = '0;
    for (i = 0; i < 100000 && rdy_in !== 1'b1; i++)
      #4;
    #401.3; // Keeps select high long enough, off the core clock phase
    ok = (rdy_in === 1'b1);
    sync_n_out = 1'b0;
    #12;
    for (i = 15; i >= 0; i--) begin
      sclk_out = 1'b1;
      sdi_out = tx[i];
      #10;
      sclk_out = 1'b0; // 20 ns period, the fastest allowed
      rx[i] = sdo_in;
      #10;
    end
    sync_n_out = 1'b1;
    sdi_out = ~sdi_out; // Released line shows no stale bit
  endtask
endmodule // spi_host_model

// file: testbench/tb_top.sv
// Self-checking bench for the serial control port
`timescale 1ns/10ps
`include "spi_busy_regs.svh"

module tb_top;
  import spi_busy_pkg::*;
  // ============================================================
  // Shortened long counts so the run stays brief
  localparam int unsigned PROG_CYC = 200;
  localparam int unsigned READ_CYC = 150;
  localparam int unsigned PWR_CYC  = 100;
  logic               clk_in = 1'b0;
  logic               rst_n_in = 1'b0;
  logic               rperf_mode_in = 1'b0;
  wire logic          sclk, sync_n, sdi, sdo, rdy_out, rdy_oe_out;
  wire logic [9:0]    wiper;
  wire logic          rdy_wire = !rdy_oe_out; // Pull-up on the wire
  int                 failures = 0;
  int                 n_tests = 0;
  int                 cyc = 0;

  always #2 clk_in = ~clk_in;

  spi_command_busy_timing #(.NVM_PROG_CYC(PROG_CYC),
    .NVM_READ_CYC(READ_CYC), .POWER_UP_CYC(PWR_CYC))
  spi_command_busy_timing_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .sclk_in(sclk), .sync_n_in(sync_n), .sdi_in(sdi), .sdo_out(sdo),
    .rperf_mode_in(rperf_mode_in), .rdy_in(rdy_wire),
    .rdy_out(rdy_out), .rdy_oe_out(rdy_oe_out), .wiper_out(wiper));

  spi_host_model spi_host_model_i (.sclk_out(sclk), .sync_n_out(sync_n),
    .sdi_out(sdi), .sdo_in(sdo), .rdy_in(rdy_wire));

  // ============================================================
  // Shared helpers
  task automatic check(input string name, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Cycles until busy has been seen and then released
  task automatic wait_idle(input bit b0, output int n);
    bit b;
    b = b0;
    n = 0;
    while (n < 5000 && !(b && rdy_oe_out === 1'b0)) begin
      @(posedge clk_in);
      #1;
      n++;
      if (rdy_oe_out === 1'b1)
        b = 1'b1;
    end
  endtask

  task automatic send(input logic [3:0] c, input logic [9:0] d,
                      output int n, output logic [15:0] rx);
    frame_t f;
    logic ok;
    f = '{spare: 2'b00, cmd: c, data: d};
    spi_host_model_i.xfer(f, rx, ok);
    check("host_ready", ok, 1'b1);
    wait_idle(1'b0, n);
  endtask

  // ============================================================
  // Scenarios
  task automatic t_power;
    int n;
    wait_idle(1'b1, n);
    check("pwr_time", n <= PWR_CYC, 1'b1);
    check("pwr_wiper", wiper, `NVM_RESET_VAL);
  endtask

  task automatic t_write;
    int n;
    logic [15:0] rx;
    send(`CMD_WR_WIPER, 10'h155, n, rx);
    check("wr_time", n <= `CYC_FLOOR(`T_WR_NORM_NS) + 1, 1'b1);
    check("wr_wiper", wiper, 10'h155);
  endtask

  // Mode pin is synchronised, so it settles a few cycles first
  task automatic t_rperf;
    int n;
    logic [15:0] rx;
    @(posedge clk_in);
    rperf_mode_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    send(`CMD_WR_WIPER, 10'h2aa, n, rx);
    check("rp_time", n <= `CYC_FLOOR(`T_WR_RPERF_NS) + 1, 1'b1);
    check("rp_wiper", wiper, 10'h2aa);
    @(posedge clk_in);
    rperf_mode_in <= 1'b0;
  endtask

  task automatic t_read;
    int n;
    logic [15:0] rx;
    send(`CMD_RD_WIPER, 10'h000, n, rx);
    check("rd_time", n <= `CYC_FLOOR(`T_RD_WIPER_NS) + 1, 1'b1);
    send(`CMD_NOP, 10'h000, n, rx);
    check("rd_word", rx, {2'b00, `CMD_RD_WIPER, 10'h2aa});
  endtask

  // Program, overwrite the wiper, then read the memory back
  task automatic t_nvm;
    int n;
    logic [15:0] rx;
    send(`CMD_NVM_PROG, 10'h000, n, rx);
    check("prog_time", n <= PROG_CYC + 1, 1'b1);
    send(`CMD_WR_WIPER, 10'h001, n, rx);
    send(`CMD_NVM_READ, 10'h000, n, rx);
    check("nvrd_time", n <= READ_CYC + 1, 1'b1);
    send(`CMD_NOP, 10'h000, n, rx);
    check("nvrd_word", rx, {2'b00, `CMD_NVM_READ, 10'h2aa});
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard, well above the few thousand cycles expected
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end

  initial begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_power();
    t_write();
    t_rperf();
    t_read();
    t_nvm();
    end_sim();
  end
endmodule // tb_top
